/* File: hdl/tsp_consts.svh */
`ifndef TSP_CONSTS_SVH
`define TSP_CONSTS_SVH

// Word and field widths
`define TSP_WORD_W          16
`define TSP_CMD_W           8
`define TSP_TEMP_W          14
`define TSP_TAIL_W          2
`define TSP_TEMP_TAIL       2'h3

// Command bytes
`define TSP_CMD_SHUTDOWN    8'hff
`define TSP_CMD_CONTINUOUS  8'h00

// Serial frame counting: bit 4 of the edge count marks the receive half
`define TSP_CNT_W           5
`define TSP_CNT_ZERO        5'h00
`define TSP_CNT_ONE         5'h01
`define TSP_PHASE_BIT       4
`define TSP_LAST_RISE       5'h1f

// Conversion timing
`define TSP_CONV_TIME_MS    300
`define TSP_CLK_KHZ         40000
`define TSP_CONV_CNT_W      24
`define TSP_CONV_CNT_ZERO   24'h000000
`define TSP_CONV_CNT_ONE    24'h000001

// Identity word, value arbitrary; low two bits stay ones
`define TSP_ID_DEFAULT      16'h2a53

// Reset values
`define TSP_WORD_RESET      16'h0000
`define TSP_CMD_RESET       8'h00
`define TSP_TEMP_RESET      14'h0000

`endif

/* File: hdl/tsp_pkg.sv */
`include "tsp_consts.svh"

package tsp_pkg;

    typedef enum logic {
        MODE_CONTINUOUS,
        MODE_SHUTDOWN
    } tsp_mode_type;

    typedef enum logic {
        CONV_IDLE,
        CONV_RUN
    } tsp_conv_type;

    typedef logic [`TSP_WORD_W-1:0] tsp_word_type;
    typedef logic [`TSP_CMD_W-1:0]  tsp_cmd_type;
    typedef logic [`TSP_TEMP_W-1:0] tsp_temp_type;

endpackage : tsp_pkg

/* File: hdl/tsp_conv_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface tsp_conv_if;
    logic                  start;
    logic                  done;
    tsp_pkg::tsp_temp_type result;

    modport ctl (output start, input done, input result);
    modport eng (input start, output done, output result);
endinterface : tsp_conv_if

`default_nettype wire

/* File: hdl/tsp_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module tsp_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Asynchronous input and its filtered level
    input  wire logic din,
    output var  logic level
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_d;

    always_comb begin
        level_d = (s2_q == s3_q) ? s3_q : level;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_q  <= RESET_VAL;
            s2_q  <= RESET_VAL;
            s3_q  <= RESET_VAL;
            level <= RESET_VAL;
        end else begin
            s1_q  <= din;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            level <= level_d;
        end
    end

endmodule : tsp_sync

`default_nettype wire

/* File: hdl/tsp_conv.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tsp_consts.svh"

module tsp_conv #(
    parameter int unsigned CONV_CYCLES = 1
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // Sensor front end
    input  wire tsp_pkg::tsp_temp_type adc_code,
    // Control side
    tsp_conv_if.eng                    cv
);

    localparam logic [`TSP_CONV_CNT_W-1:0] LAST =
        `TSP_CONV_CNT_W'(CONV_CYCLES - 1);

    tsp_pkg::tsp_conv_type      st_q, st_d;
    logic [`TSP_CONV_CNT_W-1:0] cnt_q, cnt_d;
    logic                       done_q, done_d;
    tsp_pkg::tsp_temp_type      res_q, res_d;

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        done_d = 1'b0;
        res_d  = res_q;
        case (st_q)
            tsp_pkg::CONV_IDLE: begin
                cnt_d = `TSP_CONV_CNT_ZERO;
                if (cv.start) begin
                    st_d = tsp_pkg::CONV_RUN;
                end
            end
            tsp_pkg::CONV_RUN: begin
                // A running conversion always completes
                if (cnt_q == LAST) begin
                    st_d   = tsp_pkg::CONV_IDLE;
                    done_d = 1'b1;
                    res_d  = adc_code;
                end else begin
                    cnt_d = cnt_q + `TSP_CONV_CNT_ONE;
                end
            end
            default: begin
                st_d = tsp_pkg::CONV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q   <= tsp_pkg::CONV_IDLE;
            cnt_q  <= `TSP_CONV_CNT_ZERO;
            done_q <= 1'b0;
            res_q  <= `TSP_TEMP_RESET;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            done_q <= done_d;
            res_q  <= res_d;
        end
    end

    assign cv.done   = done_q;
    assign cv.result = res_q;

endmodule : tsp_conv

`default_nettype wire

/* File: hdl/tsp_top.sv */
// Functional notes
// - Reset leaves the device in continuous conversion, not shutdown.
// - Read word is meaningless until the first conversion completes.
// - Output changes on falling edges; input sampled on rising edges.
// - A frame is 16 transmit clocks followed by 16 receive clocks.
// - Data line is released whenever chip select is high.
// - First bit drives when chip select falls; rest follow falling edges.
// - Host may raise chip select mid-transmit; device stops driving at once.
// - Result finished during a frame loads only after chip select rises.
// - Receive bits shift into 8 bits; last eight before release count.
// - Command all ones means shutdown; all zeros means continuous.
// - Low byte all ones selects shutdown whatever the high byte holds.
// - Word is 14-bit two's complement temperature plus two one bits.
// - Word goes out most significant bit first.
// - In shutdown the port works and every read returns the identity.
// - Identity word leads with a five-bit maker code.
// - Temperature and identity are read-only; mode is write-only.
// - End of a read refreshes the output word and, in continuous mode, lets an idle converter start again.
`timescale 1ns/1ps
`default_nettype none
`include "tsp_consts.svh"

module tsp_top #(
    parameter tsp_pkg::tsp_word_type ID_WORD     = `TSP_ID_DEFAULT,
    parameter int unsigned           CONV_CYCLES =
        `TSP_CONV_TIME_MS * `TSP_CLK_KHZ
) (
    // System clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // Serial link pins
    input  wire logic                  serial_clock,
    input  wire logic                  cs_n,
    input  wire logic                  sio_in,
    output var  logic                  sio_out,
    output var  logic                  sio_oe,
    // Sensor front end
    input  wire tsp_pkg::tsp_temp_type adc_code,
    // Status
    output var  logic                  mode_shutdown,
    output var  logic                  result_valid
);

    // Mode decode shared by the link and the system side
    function automatic tsp_pkg::tsp_mode_type apply_cmd(
        input tsp_pkg::tsp_cmd_type  cmd,
        input tsp_pkg::tsp_mode_type cur
    );
        tsp_pkg::tsp_mode_type nxt;
        nxt = cur;
        if (cmd == `TSP_CMD_SHUTDOWN) begin
            nxt = tsp_pkg::MODE_SHUTDOWN;
        end else if (cmd == `TSP_CMD_CONTINUOUS) begin
            nxt = tsp_pkg::MODE_CONTINUOUS;
        end
        // Other codes are left without effect instead of a test mode
        return nxt;
    endfunction : apply_cmd

    // ------------------------------------------------------------------
    // System clock side
    // ------------------------------------------------------------------
    tsp_conv_if conv_bus ();

    logic                  cs_level;
    logic                  cs_prev_q, cs_prev_d;
    logic                  frame_end;
    tsp_pkg::tsp_mode_type mode_q, mode_d;
    tsp_pkg::tsp_word_type word_q, word_d;
    tsp_pkg::tsp_temp_type temp_q, temp_d;
    logic                  valid_q, valid_d;

    // Link-side command state read after the frame has ended
    tsp_pkg::tsp_cmd_type  cmd_q, cmd_d;
    logic                  cmd_seen_q, cmd_seen_d;

    tsp_sync #(
        .RESET_VAL (1'b1)
    ) u_cs_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    (cs_n),
        .level  (cs_level)
    );

    tsp_conv #(
        .CONV_CYCLES (CONV_CYCLES)
    ) u_conv (
        .clk      (clk),
        .resetn   (resetn),
        .adc_code (adc_code),
        .cv       (conv_bus.eng)
    );

    assign frame_end = cs_level & ~cs_prev_q;

    // Conversions restart only between frames; one already running may still
    // finish mid-frame, and only the word gate keeps it from the host shifting out
    assign conv_bus.start = cs_level &&
                            (mode_q == tsp_pkg::MODE_CONTINUOUS);

    always_comb begin
        cs_prev_d = cs_level;
        mode_d    = mode_q;
        temp_d    = temp_q;
        valid_d   = valid_q;
        word_d    = word_q;

        if (frame_end && cmd_seen_q) begin
            mode_d = apply_cmd(cmd_q, mode_q);
        end

        if (conv_bus.done && mode_q == tsp_pkg::MODE_CONTINUOUS) begin
            temp_d  = conv_bus.result;
            valid_d = 1'b1;
        end
        if (mode_d == tsp_pkg::MODE_SHUTDOWN) begin
            valid_d = 1'b0;
        end

        // The word only moves while chip select is seen high
        if (cs_level) begin
            if (mode_q == tsp_pkg::MODE_SHUTDOWN) begin
                word_d = ID_WORD;
            end else begin
                word_d = {temp_q, `TSP_TEMP_TAIL};
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cs_prev_q <= 1'b1;
            mode_q    <= tsp_pkg::MODE_CONTINUOUS;
            temp_q    <= `TSP_TEMP_RESET;
            valid_q   <= 1'b0;
            word_q    <= `TSP_WORD_RESET;
        end else begin
            cs_prev_q <= cs_prev_d;
            mode_q    <= mode_d;
            temp_q    <= temp_d;
            valid_q   <= valid_d;
            word_q    <= word_d;
        end
    end

    assign mode_shutdown = (mode_q == tsp_pkg::MODE_SHUTDOWN);
    assign result_valid  = valid_q;

    // ------------------------------------------------------------------
    // Serial clock side
    // ------------------------------------------------------------------
    // Frame counters clear asynchronously while chip select is high, so
    // a frame cut short leaves nothing behind for the next one
    logic                  frame_clr;
    logic [`TSP_CNT_W-1:0] rise_cnt_q, rise_cnt_d;
    logic [`TSP_CNT_W-1:0] fall_cnt_q, fall_cnt_d;
    tsp_pkg::tsp_mode_type link_mode_q, link_mode_d;
    tsp_pkg::tsp_cmd_type  cmd_next;
    logic                  rx_phase;
    tsp_pkg::tsp_word_type tx_word;

    assign frame_clr = cs_n | ~resetn;
    assign rx_phase  = rise_cnt_q[`TSP_PHASE_BIT];
    assign cmd_next  = {cmd_q[`TSP_CMD_W-2:0], sio_in};

    always_comb begin
        rise_cnt_d  = rise_cnt_q + `TSP_CNT_ONE;
        link_mode_d = link_mode_q;
        cmd_d       = cmd_q;
        cmd_seen_d  = cmd_seen_q;
        if (rise_cnt_q == `TSP_CNT_ZERO) begin
            cmd_seen_d = 1'b0;
        end
        if (rx_phase) begin
            cmd_d      = cmd_next;
            cmd_seen_d = 1'b1;
        end
        // A completed 16-bit write acts at once inside the frame so the
        // next transmit half can already carry the identity word
        if (rise_cnt_q == `TSP_LAST_RISE) begin
            link_mode_d = apply_cmd(cmd_next, link_mode_q);
        end
    end

    always_ff @(posedge serial_clock or posedge frame_clr) begin
        if (frame_clr) begin
            rise_cnt_q  <= `TSP_CNT_ZERO;
            link_mode_q <= tsp_pkg::MODE_CONTINUOUS;
        end else begin
            rise_cnt_q  <= rise_cnt_d;
            link_mode_q <= link_mode_d;
        end
    end

    // Command bits survive the frame end; the system side reads them
    // after the chip select rise has passed its synchroniser
    always_ff @(posedge serial_clock or negedge resetn) begin
        if (!resetn) begin
            cmd_q      <= `TSP_CMD_RESET;
            cmd_seen_q <= 1'b0;
        end else begin
            cmd_q      <= cmd_d;
            cmd_seen_q <= cmd_seen_d;
        end
    end

    always_comb begin
        fall_cnt_d = fall_cnt_q + `TSP_CNT_ONE;
    end

    always_ff @(negedge serial_clock or posedge frame_clr) begin
        if (frame_clr) begin
            fall_cnt_q <= `TSP_CNT_ZERO;
        end else begin
            fall_cnt_q <= fall_cnt_d;
        end
    end

    assign tx_word = (link_mode_q == tsp_pkg::MODE_SHUTDOWN) ?
                     ID_WORD : word_q;

    // The first bit must appear with no clock edge, so the data pin is a
    // select of stable words rather than a flop behind the serial clock
    assign sio_out = tx_word[~fall_cnt_q[`TSP_PHASE_BIT-1:0]];
    assign sio_oe  = ~cs_n & ~fall_cnt_q[`TSP_PHASE_BIT];

endmodule : tsp_top

`default_nettype wire

/* File: verif/tsp_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module tsp_top_asserts #(
    parameter int unsigned CONV_CYCLES = 1
) (
    // Clocks and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic serial_clock,
    // Link pins
    input wire logic cs_n,
    input wire logic sio_out,
    input wire logic sio_oe,
    // Status
    input wire logic mode_shutdown,
    input wire logic result_valid
);
    logic [4:0]  fall_q;
    int unsigned run_q;

    // Cleared while deselected, so an aborted frame leaves no residue
    always_ff @(negedge serial_clock or posedge cs_n) begin
        if (cs_n)
            fall_q <= 5'h00;
        else
            fall_q <= fall_q + 5'h01;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            run_q <= 0;
        else if (mode_shutdown)
            run_q <= 0;
        else if (run_q != 32'hffff_ffff)
            run_q <= run_q + 1;
    end

    chk_release_cs: assert property (@(posedge clk)
        disable iff (!resetn) cs_n |-> !sio_oe)
        else $error("data line driven while deselected");
    chk_first_bit: assert property (@(posedge clk)
        disable iff (!resetn) $fell(cs_n) |-> sio_oe)
        else $error("first bit not driven");
    chk_oe_phase: assert property (@(posedge serial_clock)
        disable iff (!resetn || cs_n) sio_oe == !fall_q[4])
        else $error("drive window off the 16 clock halves");
    chk_bit_stable: assert property (@(posedge clk)
        disable iff (!resetn)
        (!cs_n && $stable(cs_n) && $stable(serial_clock) && $stable(sio_oe))
        |-> $stable(sio_out)) else $error("output moved without a fall");
    chk_mode_reset: assert property (@(posedge clk)
        disable iff (!resetn) $rose(resetn) |-> !mode_shutdown)
        else $error("reset mode wrong");
    chk_mode_at_cs: assert property (@(posedge clk)
        disable iff (!resetn)
        !$stable(mode_shutdown) |-> cs_n && !$past(cs_n, 8))
        else $error("mode changed outside frame end");
    chk_valid_clear: assert property (@(posedge clk)
        disable iff (!resetn)
        $rose(mode_shutdown) |-> ##[0:2] !result_valid)
        else $error("result kept in shutdown");
    chk_valid_run: assert property (@(posedge clk)
        disable iff (!resetn)
        $rose(result_valid) |-> run_q >= CONV_CYCLES && !mode_shutdown)
        else $error("result before conversion time");

    cov_shutdown: cover property (@(posedge clk) $rose(mode_shutdown));
    cov_resume: cover property (@(posedge clk) $fell(mode_shutdown));
    cov_result: cover property (@(posedge clk) $rose(result_valid));
endmodule : tsp_top_asserts

bind tsp_top tsp_top_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
    .clk(clk), .resetn(resetn), .serial_clock(serial_clock),
    .cs_n(cs_n), .sio_out(sio_out), .sio_oe(sio_oe),
    .mode_shutdown(mode_shutdown), .result_valid(result_valid));

`default_nettype wire

/* File: verif/tsp_host.sv */
`timescale 1ns/1ps
`default_nettype none

module tsp_host (
    // Link pins
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic sio_in,
    // Device drive
    input  wire logic sio_out,
    input  wire logic sio_oe
);
    logic h_oe = 1'b0;
    logic h_d  = 1'b0;
    logic junk = 1'b0;

    // A floating line must not read as a tidy constant
    initial forever #20 junk = ~junk;
    always_comb sio_in = sio_oe ? sio_out : (h_oe ? h_d : junk);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end

    task automatic frame(input int n, input logic [31:0] wr,
                         output logic [31:0] rd);
        int p;
        rd = 32'h0;
        cs_n = 1'b0;
        #100;
        for (int k = 0; k < n; k++) begin
            p = k % 32;
            h_oe = (p >= 16);
            if (p >= 16)
                h_d = wr[(k >= 32) ? 31 - p : 47 - p];
            #40 sclk = 1'b1;
            if (p < 16)
                rd = {rd[30:0], sio_in};
            #40 sclk = 1'b0;
        end
        // The device takes the line back at the last fall of a half frame
        h_oe = 1'b0;
        #40 cs_n = 1'b1;
        #400;
    endtask : frame
endmodule : tsp_host

`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tsp_consts.svh"

module tb_top;
    localparam int unsigned           CONV = 20;
    localparam tsp_pkg::tsp_word_type ID   = `TSP_ID_DEFAULT;
    logic                  clk;
    logic                  resetn;
    logic                  sclk;
    logic                  cs_n;
    logic                  sio_in;
    logic                  sio_out;
    logic                  sio_oe;
    logic                  mode_sd;
    logic                  rvalid;
    tsp_pkg::tsp_temp_type adc;
    logic [31:0]           rd;
    int                    error_cnt = 0;
    int                    samples_checked = 0;
    int                    cyc = 0;

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    tsp_top #(.ID_WORD(ID), .CONV_CYCLES(CONV)) u_dut (
        .clk(clk), .resetn(resetn), .serial_clock(sclk), .cs_n(cs_n),
        .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe),
        .adc_code(adc), .mode_shutdown(mode_sd), .result_valid(rvalid));
    tsp_host u_host (.sclk(sclk), .cs_n(cs_n), .sio_in(sio_in),
        .sio_out(sio_out), .sio_oe(sio_oe));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string msg);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic wait_valid;
        for (int i = 0; i < 200 && rvalid !== 1'b1; i++)
            @(negedge clk);
    endtask : wait_valid

    task automatic t_temp;
        tsp_pkg::tsp_temp_type codes [2] = '{14'h0320, 14'h3b00};
        foreach (codes[i]) begin
            @(negedge clk);
            adc = codes[i];
            repeat (80) @(negedge clk);
            wait_valid();
            u_host.frame(32, 32'h0, rd);
            check(rd[15:0], {codes[i], 2'h3}, "temp word");
            check(16'(mode_sd), 16'h0, "mode after 00");
        end
    endtask : t_temp

    task automatic t_abort;
        u_host.frame(4, 32'h0, rd);
        check(16'(sio_oe), 16'h0, "released after abort");
        check(rd[15:0], {12'h0, adc[13:10]}, "leading bits");
        u_host.frame(32, 32'h0, rd);
        check(rd[15:0], {adc, 2'h3}, "word after abort");
    endtask : t_abort

    task automatic t_busy;
        tsp_pkg::tsp_temp_type old_code;
        old_code = adc;
        @(negedge clk);
        // New code arrives once the frame is seen, so only later loads see it
        fork
            u_host.frame(64, 32'h0, rd);
            begin
                repeat (8) @(negedge clk);
                adc = 14'h0c80;
            end
        join
        check(rd[31:16], {old_code, 2'h3}, "held in frame");
        check(rd[15:0], {old_code, 2'h3}, "held second half");
        repeat (40) @(negedge clk);
        u_host.frame(32, 32'h0, rd);
        check(rd[15:0], {adc, 2'h3}, "loaded after frame");
    endtask : t_busy

    task automatic t_shutdown;
        u_host.frame(32, 32'h12ff_0000, rd);
        check(16'(mode_sd), 16'h1, "shutdown");
        check(16'(rvalid), 16'h0, "result cleared");
        u_host.frame(32, 32'h005a_0000, rd);
        check(rd[15:0], ID, "id word");
        check(16'(mode_sd), 16'h1, "odd code ignored");
        u_host.frame(16, 32'h0, rd);
        check(rd[15:0], ID, "id short frame");
        check(16'(mode_sd), 16'h1, "no receive bits");
    endtask : t_shutdown

    task automatic t_resume;
        u_host.frame(32, 32'h0, rd);
        check(16'(mode_sd), 16'h0, "resumed");
        check(16'(rvalid), 16'h0, "no result yet");
        wait_valid();
        check(16'(rvalid), 16'h1, "conversion done");
        repeat (5) @(negedge clk);
        u_host.frame(64, 32'hffff_0000, rd);
        check(rd[31:16], {adc, 2'h3}, "temp then id");
        check(rd[15:0], ID, "id in frame");
        check(16'(mode_sd), 16'h0, "final 00 applies");
    endtask : t_resume

    initial begin
        resetn = 1'b0;
        adc = 14'h0;
        repeat (5) @(negedge clk);
        check(16'(sio_oe), 16'h0, "idle line");
        resetn = 1'b1;
        @(negedge clk);
        check(16'(mode_sd), 16'h0, "reset mode");
        check(16'(rvalid), 16'h0, "no result");
        t_temp();
        t_abort();
        t_busy();
        t_shutdown();
        t_resume();
        test_done();
    end
endmodule : tb_top

`default_nettype wire
